// >>> src/buck_cfg_pkg.sv
// Constants, field layouts and carrier types for the step-down regulator
// configuration bank.
// Assumes a byte-wide register access port driven by the chip's serial control logic.
package buck_cfg_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_PERI_PROG_LIMITS = 8'h9B;
  localparam logic [7:0] ADDR_CORE_LIMITS = 8'h9C;
  localparam logic [7:0] ADDR_CORE_TWO_CONFIG = 8'h9D;
  localparam logic [7:0] ADDR_CORE_ONE_CONFIG = 8'h9E;
  localparam logic [7:0] ADDR_PROG_CONFIG = 8'h9F;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int LIMIT_HI_MSB = 7;
  localparam int LIMIT_HI_LSB = 4;
  localparam int LIMIT_LO_MSB = 3;
  localparam int LIMIT_LO_LSB = 0;
  localparam int MODE_MSB = 7;
  localparam int MODE_LSB = 6;
  localparam int PD_OFF_BIT = 5;
  localparam int VTT_EN_BIT = 4;
  localparam int TERMINATION_REFERENCE_PORT_EN_BIT = 3;
  localparam int FB_MSB = 2;
  localparam int FB_LSB = 0;

  // Writable bits of the core configuration registers; bits 4:3 are reserved.
  localparam logic [7:0] CORE_CONFIG_WMASK = 8'hE7;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_LIMITS = 8'h00;
  // Feedback mask resets to the regulator's own output, a valid source.
  localparam logic [7:0] RST_CONFIG = 8'h01;

  // ----------------------------------------------------------------------
  // Current limit scale in mA
  // ----------------------------------------------------------------------
  localparam int LIMIT_W = 12;
  localparam logic [LIMIT_W-1:0] LIMIT_BASE_MA = 12'h1F4;
  localparam logic [LIMIT_W-1:0] LIMIT_STEP_MA = 12'h064;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_BY_VOLTAGE_REG = 2'h0,
    MODE_FORCED_SLEEP = 2'h1,
    MODE_FORCED_SYNC = 2'h2,
    MODE_AUTOMATIC = 2'h3
  } op_mode_e;

  typedef struct packed {
    op_mode_e op_mode;
    logic pulldown_en;
    logic [2:0] feedback_sel;
    logic diff_remote_sense;
    logic sense_mixer_off;
    logic feedback_invalid;
    logic [LIMIT_W-1:0] limit_ma;
  } buck_ctrl_s;

  typedef struct packed {
    logic termination_track;
    logic reference_output_enable;
    logic external_comparator_route;
  } term_ctrl_s;

  // Limit in mA for a four-bit code, doubled in full-current mode.
  function automatic logic [LIMIT_W-1:0] limit_from_code(input logic [3:0] code,
                                                         input logic full);
    logic [LIMIT_W-1:0] base;
    base = LIMIT_BASE_MA + LIMIT_STEP_MA * {8'h00, code};
    limit_from_code = full ? {base[LIMIT_W-2:0], 1'b0} : base;
  endfunction

endpackage

// >>> src/buck_channel_decode.sv
// Decodes one regulator's configuration fields into registered control levels.
// Assumes fields and mode inputs are on the same clock as this module.
`timescale 1ns/1ps
module buck_channel_decode #(
  parameter bit MERGE_SENSE = 1'b0
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Configuration fields
  input wire logic [3:0] limit_code,
  input wire logic [7:0] config_byte,
  input wire logic full_current,
  input wire logic pulldown_block,
  input wire logic merged,
  // Decoded controls
  output buck_cfg_pkg::buck_ctrl_s ctrl
);
  import buck_cfg_pkg::*;

  buck_ctrl_s ctrl_d;
  buck_ctrl_s ctrl_q;
  logic [2:0] fb;

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  always_comb begin
    fb = config_byte[FB_MSB:FB_LSB];
    ctrl_d.op_mode = op_mode_e'(config_byte[MODE_MSB:MODE_LSB]);
    ctrl_d.pulldown_en = !config_byte[PD_OFF_BIT] && !pulldown_block;
    ctrl_d.feedback_sel = fb;
    ctrl_d.diff_remote_sense = 1'b0;
    ctrl_d.sense_mixer_off = 1'b0;
    ctrl_d.feedback_invalid = 1'b0;
    ctrl_d.limit_ma = limit_from_code(limit_code, full_current);
    if (fb == 3'h0) begin
      if (MERGE_SENSE) begin
        // Merged pair senses differentially; alone, code zero means own output.
        ctrl_d.sense_mixer_off = 1'b1;
        ctrl_d.diff_remote_sense = merged;
        ctrl_d.feedback_sel = merged ? 3'h0 : 3'h1;
      end else begin
        // Nothing is sensed; the flag lets supervisory logic catch the bad write.
        ctrl_d.feedback_invalid = 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ctrl_q <= '0;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  assign ctrl = ctrl_q;

endmodule // buck_channel_decode

// >>> src/buck_cfg_regs.sv
// Configuration register bank for the core regulator pair and the
// programmable regulator, with decoded static controls for the converters.
// Assumes a byte register port from the serial control logic on the same
// clock, and full-current, merge and dual-phase levels from same-clock logic.
//
// Function
// - Programmable limit code in bits 3:0: 500 mA plus 100 mA per step, doubled full-current.
// - Core two limit in bits 7:4 of 0x9C, same scale, doubled full-current.
// - Core one limit in bits 3:0 of 0x9C, same scale, doubled full-current.
// - Core two mode bits 7:6: register, sleep, synchronous, automatic.
// - Core one mode bits 7:6 of 0x9E, same four-value encoding.
// - Programmable mode bits 7:6 of 0x9F, same four-value encoding.
// - Core two bit 5 low enables pull-down, except in dual-phase operation.
// - Core one and programmable bit 5 low connect the disabled pull-down.
// - Core two feedback mask bits 2:0 pick sources; zero is invalid.
// - Core one code zero: own output unmerged, differential sensing when merged.
// - Core one mask combines sources; zero turns the sense mixer off.
// - Programmable feedback mask combines sources; zero is invalid.
// - Bit 3 low routes reference port to comparator; high drives half voltage.
`timescale 1ns/1ps
module buck_cfg_regs (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Register access from the serial control port
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  output logic reg_hit,
  // Operating levels from the rest of the chip
  input wire logic full_current_mode,
  input wire logic core_pair_merged,
  input wire logic dual_phase_mode,
  // Decoded controls to the converters
  output buck_cfg_pkg::buck_ctrl_s core_one_ctrl,
  output buck_cfg_pkg::buck_ctrl_s core_two_ctrl,
  output buck_cfg_pkg::buck_ctrl_s prog_reg_ctrl,
  output buck_cfg_pkg::term_ctrl_s term_ctrl,
  output logic [3:0] peri_current_limit
);
  import buck_cfg_pkg::*;

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  logic [7:0] peri_prog_limits_q, peri_prog_limits_d;
  logic [7:0] core_limits_q, core_limits_d;
  logic [7:0] core_two_config_q, core_two_config_d;
  logic [7:0] core_one_config_q, core_one_config_d;
  logic [7:0] prog_config_q, prog_config_d;
  logic [7:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  logic hit_q, hit_d;
  term_ctrl_s term_q, term_d;
  logic [7:0] read_mux;
  logic addr_known;

  // Field views used by the decoders and the termination control.
  logic [3:0] prog_reg_current_limit;
  logic [3:0] core_two_current_limit;
  logic [3:0] core_one_current_limit;
  logic termination_track_enable;
  logic reference_output_enable;

  assign prog_reg_current_limit = peri_prog_limits_q[LIMIT_LO_MSB:LIMIT_LO_LSB];
  assign core_two_current_limit = core_limits_q[LIMIT_HI_MSB:LIMIT_HI_LSB];
  assign core_one_current_limit = core_limits_q[LIMIT_LO_MSB:LIMIT_LO_LSB];
  assign termination_track_enable = prog_config_q[VTT_EN_BIT];
  assign reference_output_enable = prog_config_q[TERMINATION_REFERENCE_PORT_EN_BIT];

  // ----------------------------------------------------------------------
  // Write path
  // ----------------------------------------------------------------------
  always_comb begin
    peri_prog_limits_d = peri_prog_limits_q;
    core_limits_d = core_limits_q;
    core_two_config_d = core_two_config_q;
    core_one_config_d = core_one_config_q;
    prog_config_d = prog_config_q;
    if (reg_write) begin
      case (reg_addr)
        ADDR_PERI_PROG_LIMITS: begin
          peri_prog_limits_d = reg_wdata;
        end
        ADDR_CORE_LIMITS: begin
          core_limits_d = reg_wdata;
        end
        ADDR_CORE_TWO_CONFIG: begin
          // Reserved bits keep their zero regardless of the written data.
          core_two_config_d = reg_wdata & CORE_CONFIG_WMASK;
        end
        ADDR_CORE_ONE_CONFIG: begin
          core_one_config_d = reg_wdata & CORE_CONFIG_WMASK;
        end
        ADDR_PROG_CONFIG: begin
          prog_config_d = reg_wdata;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      peri_prog_limits_q <= RST_LIMITS;
      core_limits_q <= RST_LIMITS;
      core_two_config_q <= RST_CONFIG;
      core_one_config_q <= RST_CONFIG;
      prog_config_q <= RST_CONFIG;
    end else begin
      peri_prog_limits_q <= peri_prog_limits_d;
      core_limits_q <= core_limits_d;
      core_two_config_q <= core_two_config_d;
      core_one_config_q <= core_one_config_d;
      prog_config_q <= prog_config_d;
    end
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  // Unmapped addresses answer zero with reg_hit low, so the serial logic can
  // still complete the transfer and flag the miss on its own terms.
  always_comb begin
    read_mux = 8'h00;
    addr_known = 1'b1;
    case (reg_addr)
      ADDR_PERI_PROG_LIMITS: begin
        read_mux = peri_prog_limits_q;
      end
      ADDR_CORE_LIMITS: begin
        read_mux = core_limits_q;
      end
      ADDR_CORE_TWO_CONFIG: begin
        read_mux = core_two_config_q & CORE_CONFIG_WMASK;
      end
      ADDR_CORE_ONE_CONFIG: begin
        read_mux = core_one_config_q & CORE_CONFIG_WMASK;
      end
      ADDR_PROG_CONFIG: begin
        read_mux = prog_config_q;
      end
      default: begin
        addr_known = 1'b0;
      end
    endcase
  end

  always_comb begin
    rdata_d = rdata_q;
    rvalid_d = 1'b0;
    hit_d = 1'b0;
    if (reg_read) begin
      rdata_d = read_mux;
      rvalid_d = 1'b1;
      hit_d = addr_known;
    end else if (reg_write) begin
      hit_d = addr_known;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
      hit_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      hit_q <= hit_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_rvalid = rvalid_q;
  assign reg_hit = hit_q;

  // ----------------------------------------------------------------------
  // Regulator decoders
  // ----------------------------------------------------------------------
  // Core two loses its pull-down whenever the pair runs dual-phase, since the
  // shared output would otherwise be loaded by the idle phase.
  buck_channel_decode #(
    .MERGE_SENSE(1'b0)
  ) u_core_two (
    .clock(clock),
    .sys_rst(sys_rst),
    .limit_code(core_two_current_limit),
    .config_byte(core_two_config_q),
    .full_current(full_current_mode),
    .pulldown_block(dual_phase_mode),
    .merged(1'b0),
    .ctrl(core_two_ctrl)
  );

  buck_channel_decode #(
    .MERGE_SENSE(1'b1)
  ) u_core_one (
    .clock(clock),
    .sys_rst(sys_rst),
    .limit_code(core_one_current_limit),
    .config_byte(core_one_config_q),
    .full_current(full_current_mode),
    .pulldown_block(1'b0),
    .merged(core_pair_merged),
    .ctrl(core_one_ctrl)
  );

  // A zero feedback mask is not blocked here: the write stands and the
  // decoder raises feedback_invalid instead.
  buck_channel_decode #(
    .MERGE_SENSE(1'b0)
  ) u_prog_reg (
    .clock(clock),
    .sys_rst(sys_rst),
    .limit_code(prog_reg_current_limit),
    .config_byte(prog_config_q),
    .full_current(full_current_mode),
    .pulldown_block(1'b0),
    .merged(1'b0),
    .ctrl(prog_reg_ctrl)
  );

  // ----------------------------------------------------------------------
  // Termination and reference port control
  // ----------------------------------------------------------------------
  always_comb begin
    term_d.termination_track = termination_track_enable && reference_output_enable;
    term_d.reference_output_enable = reference_output_enable;
    term_d.external_comparator_route = !reference_output_enable;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      term_q <= '0;
    end else begin
      term_q <= term_d;
    end
  end

  assign term_ctrl = term_q;
  assign peri_current_limit = peri_prog_limits_q[LIMIT_HI_MSB:LIMIT_HI_LSB];

endmodule // buck_cfg_regs

// >>> sim/buck_cfg_chk.sv
// Concurrent checks for the regulator configuration bank.
// Bound to buck_cfg_regs below; sees only its ports, one clock domain.
`timescale 1ns/1ps
module buck_cfg_chk
  import buck_cfg_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Register port
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic reg_hit,
  // Operating levels
  input wire logic full_current_mode,
  input wire logic core_pair_merged,
  input wire logic dual_phase_mode,
  // Decoded controls
  input wire buck_cfg_pkg::buck_ctrl_s core_one_ctrl,
  input wire buck_cfg_pkg::buck_ctrl_s core_two_ctrl,
  input wire buck_cfg_pkg::buck_ctrl_s prog_reg_ctrl,
  input wire buck_cfg_pkg::term_ctrl_s term_ctrl,
  input wire logic [3:0] peri_current_limit
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  wire mapped = reg_addr >= ADDR_PERI_PROG_LIMITS && reg_addr <= ADDR_PROG_CONFIG;

  // --------------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------------
  // A second write in the next cycle would move the decode, so only lone writes count.
  sequence s_wr(logic [7:0] a);
    reg_write && reg_addr == a ##1 !(reg_write && reg_addr == a);
  endsequence

  property p_limit(logic [7:0] a, logic [3:0] code, logic [11:0] got);
    s_wr(a) |=> got == (LIMIT_BASE_MA + LIMIT_STEP_MA * {8'h00, $past(code, 2)})
      << $past(full_current_mode);
  endproperty

  a_prog_limit: assert property (p_limit(ADDR_PERI_PROG_LIMITS, reg_wdata[3:0],
    prog_reg_ctrl.limit_ma)) else $error("prog limit wrong");
  a_core_two_limit: assert property (p_limit(ADDR_CORE_LIMITS, reg_wdata[7:4],
    core_two_ctrl.limit_ma)) else $error("core two limit wrong");
  a_core_one_limit: assert property (p_limit(ADDR_CORE_LIMITS, reg_wdata[3:0],
    core_one_ctrl.limit_ma)) else $error("core one limit wrong");
  a_core_two_mode: assert property (s_wr(ADDR_CORE_TWO_CONFIG) |=>
    core_two_ctrl.op_mode == $past(reg_wdata[7:6], 2)) else $error("core two mode wrong");
  a_dual_no_pulldown: assert property (dual_phase_mode |=> !core_two_ctrl.pulldown_en)
    else $error("pull-down on in dual phase");
  a_core_one_pulldown: assert property (s_wr(ADDR_CORE_ONE_CONFIG) |=>
    core_one_ctrl.pulldown_en == !$past(reg_wdata[5], 2)) else $error("pull-down wrong");
  a_fb_zero_core: assert property (
    s_wr(ADDR_CORE_ONE_CONFIG) ##0 $past(reg_wdata[2:0]) == 3'h0 |=>
    core_one_ctrl.feedback_sel == ($past(core_pair_merged) ? 3'h0 : 3'h1))
    else $error("core one zero feedback wrong");
  a_term_fields: assert property (s_wr(ADDR_PROG_CONFIG) |=>
    term_ctrl.termination_track == &$past(reg_wdata[4:3], 2) &&
    term_ctrl.external_comparator_route == !$past(reg_wdata[3], 2))
    else $error("termination controls wrong");
  a_reserved_zero: assert property (reg_read && reg_addr inside {8'h9D, 8'h9E} |=>
    reg_rdata[4:3] == 2'b00) else $error("reserved bits read nonzero");
  // Read data may only move in the cycle after a further read was taken.
  a_read_answer: assert property (reg_read |=> reg_rvalid ##1 ($stable(reg_rdata) ||
    $past(reg_read)))
    else $error("read answer wrong");
  a_unmapped_miss: assert property ((reg_read || reg_write) && !mapped |=> !reg_hit)
    else $error("hit on unmapped address");
endmodule // buck_cfg_chk

bind buck_cfg_regs buck_cfg_chk chk (
  .clock(clock), .sys_rst(sys_rst), .reg_write(reg_write), .reg_read(reg_read),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .reg_hit(reg_hit), .full_current_mode(full_current_mode),
  .core_pair_merged(core_pair_merged), .dual_phase_mode(dual_phase_mode),
  .core_one_ctrl(core_one_ctrl), .core_two_ctrl(core_two_ctrl),
  .prog_reg_ctrl(prog_reg_ctrl), .term_ctrl(term_ctrl),
  .peri_current_limit(peri_current_limit)
);

// >>> sim/tb.sv
// Self-checking bench for the regulator configuration bank.
// Drives the byte register port and level inputs directly on falling edges.
`timescale 1ns/1ps
module tb;
  import buck_cfg_pkg::*;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic reg_hit;
  logic full_current_mode = 1'b0;
  logic core_pair_merged = 1'b0;
  logic dual_phase_mode = 1'b0;
  buck_ctrl_s core_one_ctrl;
  buck_ctrl_s core_two_ctrl;
  buck_ctrl_s prog_reg_ctrl;
  term_ctrl_s term_ctrl;
  logic [3:0] peri_current_limit;
  logic [7:0] b;
  int failures = 0;
  int samples_checked = 0;

  buck_cfg_regs dut (
    .clock(clock), .sys_rst(sys_rst), .reg_write(reg_write), .reg_read(reg_read),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .reg_hit(reg_hit), .full_current_mode(full_current_mode),
    .core_pair_merged(core_pair_merged), .dual_phase_mode(dual_phase_mode),
    .core_one_ctrl(core_one_ctrl), .core_two_ctrl(core_two_ctrl),
    .prog_reg_ctrl(prog_reg_ctrl), .term_ctrl(term_ctrl),
    .peri_current_limit(peri_current_limit)
  );

  initial begin
    forever #50 clock = ~clock;
  end

  // --------------------------------------------------------------------
  // Access and compare tasks
  // --------------------------------------------------------------------
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t byte %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_ctl(input logic [11:0] got, input logic [11:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t control %h expected %h", $time, got, exp);
    end
  endtask

  // Returns after the decode of the write has had its extra edge to settle.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_write = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clock);
    reg_write = 1'b0;
    @(negedge clock);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic hit);
    @(negedge clock);
    reg_read = 1'b1;
    reg_addr = a;
    @(negedge clock);
    reg_read = 1'b0;
    chk_reg(reg_rdata, exp);
    chk_reg({6'h00, reg_rvalid, reg_hit}, {6'h00, 1'b1, hit});
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge clock);
    failures++;
    $display("ERROR t=%0t watchdog expired", $time);
    conclude();
  end

  // --------------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------------
  initial begin
    repeat (10) @(negedge clock);
    sys_rst = 1'b0;
    rd(ADDR_CORE_LIMITS, 8'h00, 1'b1);
    rd(ADDR_CORE_TWO_CONFIG, 8'h01, 1'b1);
    rd(8'hA0, 8'h00, 1'b0);
    chk_ctl(core_two_ctrl.limit_ma, 12'd500);
    $display("test reset done");
    for (int f = 0; f < 2; f++) begin
      full_current_mode = f[0];
      for (int c = 0; c < 16; c++) begin
        wr(ADDR_CORE_LIMITS, {c[3:0], ~c[3:0]});
        wr(ADDR_PERI_PROG_LIMITS, {~c[3:0], c[3:0]});
        rd(ADDR_CORE_LIMITS, {c[3:0], ~c[3:0]}, 1'b1);
        chk_ctl(core_two_ctrl.limit_ma, 12'((500 + 100 * c) << f));
        chk_ctl(core_one_ctrl.limit_ma, 12'((2000 - 100 * c) << f));
        chk_ctl(prog_reg_ctrl.limit_ma, 12'((500 + 100 * c) << f));
        chk_ctl({8'h00, peri_current_limit}, 12'(15 - c));
      end
    end
    full_current_mode = 1'b0;
    $display("test limits done");
    for (int m = 0; m < 4; m++) begin
      b = {m[1:0], m[0], 2'b11, 3'(m + 1)};
      wr(ADDR_CORE_TWO_CONFIG, b);
      wr(ADDR_CORE_ONE_CONFIG, b);
      wr(ADDR_PROG_CONFIG, b);
      rd(ADDR_CORE_TWO_CONFIG, b & 8'hE7, 1'b1);
      rd(ADDR_CORE_ONE_CONFIG, b & 8'hE7, 1'b1);
      rd(ADDR_PROG_CONFIG, b, 1'b1);
      chk_ctl({6'h00, core_two_ctrl.op_mode, core_two_ctrl.pulldown_en,
        core_two_ctrl.feedback_sel}, {6'h00, m[1:0], ~m[0], 3'(m + 1)});
      chk_ctl({6'h00, core_one_ctrl.op_mode, core_one_ctrl.pulldown_en,
        core_one_ctrl.feedback_sel}, {6'h00, m[1:0], ~m[0], 3'(m + 1)});
      chk_ctl({6'h00, prog_reg_ctrl.op_mode, prog_reg_ctrl.pulldown_en,
        prog_reg_ctrl.feedback_sel}, {6'h00, m[1:0], ~m[0], 3'(m + 1)});
    end
    wr(ADDR_CORE_TWO_CONFIG, 8'h01);
    dual_phase_mode = 1'b1;
    repeat (2) @(negedge clock);
    chk_ctl({11'h000, core_two_ctrl.pulldown_en}, 12'h000);
    dual_phase_mode = 1'b0;
    $display("test modes done");
    wr(ADDR_CORE_TWO_CONFIG, 8'h00);
    wr(ADDR_CORE_ONE_CONFIG, 8'h00);
    wr(ADDR_PROG_CONFIG, 8'h00);
    chk_ctl({11'h000, core_two_ctrl.feedback_invalid}, 12'h001);
    chk_ctl({11'h000, prog_reg_ctrl.feedback_invalid}, 12'h001);
    chk_ctl({8'h00, core_one_ctrl.sense_mixer_off, core_one_ctrl.feedback_sel}, 12'h009);
    core_pair_merged = 1'b1;
    repeat (2) @(negedge clock);
    chk_ctl({8'h00, core_one_ctrl.diff_remote_sense, core_one_ctrl.feedback_sel}, 12'h008);
    core_pair_merged = 1'b0;
    for (int v = 0; v < 4; v++) begin
      wr(ADDR_PROG_CONFIG, {3'b000, v[1:0], 3'b001});
      chk_ctl({9'h000, term_ctrl}, {9'h000, v[1] & v[0], v[0], ~v[0]});
    end
    wr(8'hA0, 8'hFF);
    rd(8'h9A, 8'h00, 1'b0);
    // The unmapped write must leave the last programmable configuration intact.
    rd(ADDR_PROG_CONFIG, 8'h19, 1'b1);
    $display("test feedback and termination done");
    conclude();
  end
endmodule // tb
